// ===== rtl/mkc_pkg.sv
// Constants for the mixer and keyclick control register bank.
// Assumes an APB slave on a 25 MHz pclk; other blocks include nothing.
//
// Notes on behaviour
// - Sidetone mute bit 15 resets muted; clearing it lets sidetone pass for single-ended sources only.
// - Sidetone gain 7 bits, half-dB steps, resets to 0 dB, saturates at 12 dB.
// - Source select: four single-ended sources, four differential mic and aux pairs.
// - Selected source reaches the ADC only while the connect bit is set.
// - Cell phone input reaches the ADC only while its bit is set.
// - Sidetone flag bit 0 reads one once applied gain equals programmed gain capped at 12 dB.
// - Writing enable one starts a keyclick; the bit self-clears when done.
// - Keyclick amplitude field of 3 bits, resets to medium code 100.
// - Keyclick tone 62.5 Hz at code 000, doubling per step, reset 1 kHz.
// - Keyclick length is two periods per code step plus two.
// - Without AGC, input gain steps half a dB every one or two word periods.
// - With AGC, the step rate bit is read-only and shows the noise flag.
// - DAC left flag bit 3 reads one once left gain has settled.
// - DAC right flag bit 2 reads one once right gain has settled.

package mkc_pkg;

    // ****************************************************************
    // Register indices and byte addresses
    // ****************************************************************
    localparam logic [9:0]  IDX_MIXER      = 10'h003;
    localparam logic [9:0]  IDX_KEYCLICK   = 10'h004;
    localparam logic [9:0]  IDX_IRQ_STATUS = 10'h008;
    localparam logic [9:0]  IDX_IRQ_MASK   = 10'h009;
    localparam logic [11:0] ADDR_MIXER      = {IDX_MIXER, 2'b00};
    localparam logic [11:0] ADDR_KEYCLICK   = {IDX_KEYCLICK, 2'b00};
    localparam logic [11:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
    localparam logic [11:0] ADDR_IRQ_MASK   = {IDX_IRQ_MASK, 2'b00};

    // ****************************************************************
    // Mixer register fields
    // ****************************************************************
    localparam int MIX_MUTE_BIT  = 15;
    localparam int MIX_GAIN_LSB  = 8;
    localparam int MIX_SEL_LSB   = 5;
    localparam int MIX_ADC_BIT   = 4;
    localparam int MIX_CELL_BIT  = 3;
    localparam int MIX_FLAG_BIT  = 0;
    localparam logic [15:0] MIXER_RST = 16'hc500;
    localparam logic [6:0]  ST_GAIN_RST = 7'h45;
    localparam logic [6:0]  ST_GAIN_MAX = 7'h5d;

    // ****************************************************************
    // Keyclick register fields
    // ****************************************************************
    localparam int KC_EN_BIT    = 15;
    localparam int KC_AMP_LSB   = 12;
    localparam int KC_RATE_BIT  = 11;
    localparam int KC_FRQ_LSB   = 8;
    localparam int KC_LEN_LSB   = 4;
    localparam int KC_DL_BIT    = 3;
    localparam int KC_DR_BIT    = 2;
    localparam logic [15:0] KEYCLICK_RST = 16'h4410;

    // ****************************************************************
    // Interrupt bits
    // ****************************************************************
    localparam int IRQ_ST_SETTLED  = 0;
    localparam int IRQ_CLICK_DONE  = 1;
    localparam int IRQ_PGA_SETTLED = 2;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam longint CLK_HZ            = 25000000;
    localparam longint TONE_BASE_FREQ_MHZ = 62500;  // 62.5 Hz in mHz
    localparam longint TONE_BASE_CYCLES_L = (CLK_HZ * 1000) / TONE_BASE_FREQ_MHZ;

endpackage : mkc_pkg

// ===== rtl/mkc_regs.sv
// Mixer routing and keyclick control registers behind an APB slave.
// Assumes word clock and ADC word select arrive asynchronously from pins;
// AGC, DAC settle and PGA target inputs come from logic on pclk.
`timescale 1ns/1ps

module mkc_regs #(
    parameter logic [18:0] TONE_BASE_CYCLES = 19'(mkc_pkg::TONE_BASE_CYCLES_L)
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        word_clock,
    input  wire logic        adc_word_select,
    input  wire logic        step_on_adc_word_select,
    input  wire logic        agc_enabled,
    input  wire logic        agc_below_noise,
    input  wire logic [6:0]  input_gain_target,
    input  wire logic        dac_left_gain_settled_flag,
    input  wire logic        dac_right_gain_settled_flag,
    output logic             sidetone_mute,
    output logic [6:0]       sidetone_gain_applied,
    output logic [3:0]       sidetone_source,
    output logic             sidetone_path_valid,
    output logic [3:0]       adc_source,
    output logic             cell_input_to_adc,
    output logic             input_gain_step_differential,
    output logic [6:0]       input_gain_applied,
    output logic             click_tone_out,
    output logic             click_tone_active,
    output logic [2:0]       click_tone_amplitude,
    output logic             irq
);

    // ****************************************************************
    // Functions
    // ****************************************************************
    // Source order: headset mic, handset mic, aux one, aux two
    function automatic logic [3:0] route_decode(input logic [2:0] sel);
        logic [3:0] r;
        r = 4'h0;
        if (!sel[2])
        begin
            r[sel[1:0]] = 1'b1;
        end
        else
        begin
            r[sel[1] ? 1 : 0] = 1'b1;
            r[sel[0] ? 3 : 2] = 1'b1;
        end
        return r;
    endfunction

    // One half-dB step toward the target
    function automatic logic [6:0] step_toward(input logic [6:0] cur, input logic [6:0] tgt);
        logic [6:0] n;
        n = cur;
        if (cur < tgt)
        begin
            n = cur + 7'h01;
        end
        else if (cur > tgt)
        begin
            n = cur - 7'h01;
        end
        return n;
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    logic        mute_q;
    logic [6:0]  st_gain_q;
    logic [2:0]  sel_q;
    logic        adc_conn_q;
    logic        cell_q;
    logic [6:0]  st_applied_q;
    logic        st_flag_q;
    logic        kc_en_q;
    logic [2:0]  kc_amp_q;
    logic        rate_q;
    logic [2:0]  kc_frq_q;
    logic [3:0]  kc_len_q;
    logic [18:0] tone_cnt_q;
    logic [5:0]  periods_q;
    logic        done_ev;
    logic [6:0]  pga_applied_q;
    logic        pga_flag_q;
    logic        half_q;
    logic [2:0]  irq_stat_q;
    logic [2:0]  irq_mask_q;
    logic [31:0] prdata_q;
    logic [2:0]  sync_q [2];
    logic [1:0]  filt_q;
    logic [1:0]  rise;
    logic        ack;
    logic        wr;
    logic        addr_ok;
    logic [6:0]  st_target;
    logic        st_settled;
    logic        pga_settled;
    logic        tick;
    logic [18:0] period;
    logic        wrap;
    logic [5:0]  len_periods;
    logic [15:0] mixer_rd;
    logic [15:0] keyclick_rd;
    logic [2:0]  irq_ev;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    // Three flops; a level counts once stages two and three agree
    for (genvar g = 0; g < 2; g++)
    begin : g_sync
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                sync_q[g] <= 3'h0;
                filt_q[g] <= 1'b0;
            end
            else
            begin
                sync_q[g] <= {sync_q[g][1:0], (g == 0) ? word_clock : adc_word_select};
                if (sync_q[g][1] == sync_q[g][2])
                begin
                    filt_q[g] <= sync_q[g][2];
                end
            end
        end
        assign rise[g] = sync_q[g][1] & sync_q[g][2] & ~filt_q[g];
    end

    // ****************************************************************
    // APB decode
    // ****************************************************************
    // Zero wait states; unmapped addresses answer with an error
    assign ack     = psel & penable;
    assign wr      = ack & pwrite;
    assign addr_ok = (paddr == mkc_pkg::ADDR_MIXER) || (paddr == mkc_pkg::ADDR_KEYCLICK)
                  || (paddr == mkc_pkg::ADDR_IRQ_STATUS) || (paddr == mkc_pkg::ADDR_IRQ_MASK);
    assign pready  = 1'b1;
    assign pslverr = ack & ~addr_ok;
    assign prdata  = prdata_q;

    assign mixer_rd = {mute_q, st_gain_q, sel_q, adc_conn_q, cell_q, 2'b00, st_settled};
    assign keyclick_rd = {kc_en_q, kc_amp_q, agc_enabled ? agc_below_noise : rate_q,
                          kc_frq_q, kc_len_q,
                          dac_left_gain_settled_flag, dac_right_gain_settled_flag, 2'b00};

    // Read data captured in the setup cycle, stable through access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h0;
        end
        else if (psel && !penable && !pwrite)
        begin
            case (paddr)
                mkc_pkg::ADDR_MIXER:      prdata_q <= {16'h0, mixer_rd};
                mkc_pkg::ADDR_KEYCLICK:   prdata_q <= {16'h0, keyclick_rd};
                mkc_pkg::ADDR_IRQ_STATUS: prdata_q <= {29'h0, irq_stat_q};
                mkc_pkg::ADDR_IRQ_MASK:   prdata_q <= {29'h0, irq_mask_q};
                default:                  prdata_q <= 32'h0;
            endcase
        end
    end

    // ****************************************************************
    // Mixer register
    // ****************************************************************
    // mute, gain, select, connect and cell, writable fields only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mute_q     <= mkc_pkg::MIXER_RST[mkc_pkg::MIX_MUTE_BIT];
            st_gain_q  <= mkc_pkg::ST_GAIN_RST;
            sel_q      <= 3'h0;
            adc_conn_q <= 1'b0;
            cell_q     <= 1'b0;
        end
        else if (wr && paddr == mkc_pkg::ADDR_MIXER)
        begin
            mute_q     <= pwdata[mkc_pkg::MIX_MUTE_BIT];
            st_gain_q  <= pwdata[mkc_pkg::MIX_GAIN_LSB +: 7];
            sel_q      <= pwdata[mkc_pkg::MIX_SEL_LSB +: 3];
            adc_conn_q <= pwdata[mkc_pkg::MIX_ADC_BIT];
            cell_q     <= pwdata[mkc_pkg::MIX_CELL_BIT];
        end
    end

    assign st_target  = (st_gain_q > mkc_pkg::ST_GAIN_MAX) ? mkc_pkg::ST_GAIN_MAX : st_gain_q;
    assign st_settled = (st_applied_q == st_target);

    // Sidetone gain steps once per word clock, avoiding zipper noise
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_applied_q <= mkc_pkg::ST_GAIN_RST;
            st_flag_q    <= 1'b1;
        end
        else
        begin
            if (rise[0])
            begin
                st_applied_q <= step_toward(st_applied_q, st_target);
            end
            st_flag_q <= st_settled;
        end
    end

    assign adc_source          = adc_conn_q ? route_decode(sel_q) : 4'h0;
    assign cell_input_to_adc   = cell_q;
    assign sidetone_source     = sel_q[2] ? 4'h0 : route_decode(sel_q);
    // differential selection drops the sidetone path
    assign sidetone_path_valid = ~sel_q[2] & ~mute_q;
    assign sidetone_mute         = mute_q;
    assign sidetone_gain_applied = st_applied_q;

    // ****************************************************************
    // Keyclick register and tone generator
    // ****************************************************************
    // amplitude, rate, frequency and length fields
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            kc_amp_q <= mkc_pkg::KEYCLICK_RST[mkc_pkg::KC_AMP_LSB +: 3];
            rate_q   <= 1'b0;
            kc_frq_q <= mkc_pkg::KEYCLICK_RST[mkc_pkg::KC_FRQ_LSB +: 3];
            kc_len_q <= mkc_pkg::KEYCLICK_RST[mkc_pkg::KC_LEN_LSB +: 4];
        end
        else if (wr && paddr == mkc_pkg::ADDR_KEYCLICK)
        begin
            kc_amp_q <= pwdata[mkc_pkg::KC_AMP_LSB +: 3];
            kc_frq_q <= pwdata[mkc_pkg::KC_FRQ_LSB +: 3];
            kc_len_q <= pwdata[mkc_pkg::KC_LEN_LSB +: 4];
            if (!agc_enabled)
            begin
                rate_q <= pwdata[mkc_pkg::KC_RATE_BIT];
            end
        end
    end

    assign period      = TONE_BASE_CYCLES >> kc_frq_q;
    assign wrap        = kc_en_q && (tone_cnt_q == period - 19'h1);
    // two periods per step plus two
    assign len_periods = {1'b0, kc_len_q, 1'b0} + 6'h02;
    assign done_ev     = wrap && (periods_q == len_periods - 6'h01);

    // start on write, self-clear when length is reached
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            kc_en_q    <= 1'b0;
            tone_cnt_q <= 19'h0;
            periods_q  <= 6'h0;
        end
        else if (wr && paddr == mkc_pkg::ADDR_KEYCLICK)
        begin
            // A write restarts or aborts the click
            kc_en_q    <= pwdata[mkc_pkg::KC_EN_BIT];
            tone_cnt_q <= 19'h0;
            periods_q  <= 6'h0;
        end
        else if (done_ev)
        begin
            kc_en_q    <= 1'b0;
            tone_cnt_q <= 19'h0;
            periods_q  <= 6'h0;
        end
        else if (wrap)
        begin
            tone_cnt_q <= 19'h0;
            periods_q  <= periods_q + 6'h01;
        end
        else if (kc_en_q)
        begin
            tone_cnt_q <= tone_cnt_q + 19'h1;
        end
    end

    // Square tone, high for the first half period
    assign click_tone_out       = kc_en_q && (tone_cnt_q < (period >> 1));
    assign click_tone_active    = kc_en_q;
    assign click_tone_amplitude = kc_amp_q;

    // ****************************************************************
    // Input PGA soft-stepping
    // ****************************************************************
    // step every word period, or every second one
    assign tick = step_on_adc_word_select ? rise[1] : rise[0];
    assign pga_settled = (pga_applied_q == input_gain_target);

    // Under AGC the PGA is driven elsewhere, so stepping here halts
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pga_applied_q <= 7'h0;
            half_q        <= 1'b0;
            pga_flag_q    <= 1'b1;
        end
        else
        begin
            pga_flag_q <= pga_settled;
            if (tick && !agc_enabled)
            begin
                half_q <= ~half_q;
                if (!rate_q || half_q)
                begin
                    pga_applied_q <= step_toward(pga_applied_q, input_gain_target);
                end
            end
        end
    end
    assign input_gain_applied           = pga_applied_q;
    assign input_gain_step_differential = rate_q;

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    assign irq_ev = {pga_settled & ~pga_flag_q, done_ev, st_settled & ~st_flag_q};

    // Sticky status, write one to clear; a new event wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_stat_q <= 3'h0;
        end
        else if (wr && paddr == mkc_pkg::ADDR_IRQ_STATUS)
        begin
            irq_stat_q <= (irq_stat_q & ~pwdata[2:0]) | irq_ev;
        end
        else
        begin
            irq_stat_q <= irq_stat_q | irq_ev;
        end
    end

    // Mask register, one enables the source
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_mask_q <= mkc_pkg::IRQ_MASK_RST;
        end
        else if (wr && paddr == mkc_pkg::ADDR_IRQ_MASK)
        begin
            irq_mask_q <= pwdata[2:0];
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_MUTE_WRITE: assert property (
        wr && paddr == mkc_pkg::ADDR_MIXER |=> sidetone_mute == $past(pwdata[15]))
        else $error("sidetone mute did not follow write");
    AST_GAIN_SAT: assert property (
        sidetone_gain_applied <= mkc_pkg::ST_GAIN_MAX)
        else $error("sidetone gain above 12 dB");
    AST_DIFF_PAIR: assert property (
        adc_conn_q && sel_q[2] |-> $countones(adc_source) == 2)
        else $error("differential selection not a pair");
    AST_NO_ST_DIFF: assert property (
        sel_q[2] |-> !sidetone_path_valid && sidetone_source == 4'h0)
        else $error("sidetone valid during differential input");
    AST_ADC_OFF: assert property (
        !adc_conn_q |-> adc_source == 4'h0)
        else $error("source connected with connect bit low");
    AST_ST_FLAG: assert property (
        $changed(st_applied_q) |-> !$past(st_settled) && $past(rise[0]))
        else $error("sidetone gain moved while settled");
    AST_CLICK_CLEAR: assert property (
        done_ev && !wr |=> !kc_en_q && !click_tone_out)
        else $error("keyclick enable not cleared");
    AST_TONE_CNT: assert property (
        tone_cnt_q < period || !kc_en_q)
        else $error("tone counter beyond period");
    AST_LEN: assert property (
        kc_en_q |-> periods_q < len_periods)
        else $error("keyclick ran past its length");
    AST_PGA_STEP: assert property (
        $changed(pga_applied_q) |-> $past(tick) && !$past(agc_enabled))
        else $error("input gain stepped without tick");
    AST_AGC_RO: assert property (
        agc_enabled && wr && paddr == mkc_pkg::ADDR_KEYCLICK |=> $stable(rate_q))
        else $error("rate bit written under AGC");
    AST_RSVD: assert property (
        mixer_rd[2:1] == 2'b00 && keyclick_rd[1:0] == 2'b00)
        else $error("reserved bits not zero");

    COV_CLICK_DONE: cover property (done_ev);
    COV_ST_STEP: cover property ($rose(st_settled));
    COV_IRQ: cover property ($rose(irq));

endmodule : mkc_regs

// ===== dv/tb_top.sv
// Self-checking bench for the mixer and keyclick register bank.
// Assumes mkc_regs with a zero-wait APB slave; the bench is the only master.
`timescale 1ns/1ps

module tb_top;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        word_clock;
    logic        agc_enabled;
    logic        agc_below_noise;
    logic        dac_flags;
    logic        dac_r;
    logic [6:0]  pga_tgt;
    logic [6:0]  pga_gain;
    logic        st_mute;
    logic        tone;
    logic        err;
    logic [6:0]  st_gain;
    logic [3:0]  st_src;
    logic        st_valid;
    logic [3:0]  adc_src;
    logic        cell_adc;
    logic        step_diff;
    logic        click_act;
    logic [2:0]  click_amp;
    logic        irq;
    logic [31:0] rd;
    int          miscompares;
    int          checks;

    // ****************************************************************
    // Design under test, short tone base so a click lasts tens of cycles
    // ****************************************************************
    mkc_regs #(.TONE_BASE_CYCLES(19'h00100)) mkc_regs_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .word_clock(word_clock),
        .adc_word_select(1'b0), .step_on_adc_word_select(1'b0),
        .agc_enabled(agc_enabled), .agc_below_noise(agc_below_noise),
        .input_gain_target(pga_tgt), .dac_left_gain_settled_flag(dac_flags),
        .dac_right_gain_settled_flag(dac_r), .sidetone_mute(st_mute),
        .sidetone_gain_applied(st_gain), .sidetone_source(st_src),
        .sidetone_path_valid(st_valid), .adc_source(adc_src),
        .cell_input_to_adc(cell_adc), .input_gain_step_differential(step_diff),
        .input_gain_applied(pga_gain), .click_tone_out(tone), .click_tone_active(click_act),
        .click_tone_amplitude(click_amp), .irq(irq)
    );

    // Clock at 25 MHz
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd  = prdata;
        err = pslverr;
        if (n >= 16)
        begin
            miscompares++;
            end_of_test();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        // Idle edge: write has landed before any compare, no double drive
        @(posedge pclk);
    endtask

    // Word clock pulses, long enough to pass the pin synchroniser
    task automatic wclk(input int n);
        repeat (n)
        begin
            word_clock <= 1'b1;
            repeat (4) @(posedge pclk);
            word_clock <= 1'b0;
            repeat (4) @(posedge pclk);
        end
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        apb(12'h00c, 1'b0, 32'h0);
        cmp("mixer reset", 32'h0000c501, rd);
        cmp("mute port", 32'h1, 32'(st_mute));
        apb(12'h010, 1'b0, 32'h0);
        cmp("keyclick reset", 32'h00004410, rd);
        cmp("amplitude port", 32'h4, 32'(click_amp));
        $display("test reset done");
    endtask

    // Every source code, with reserved and flag bits written as ones
    task automatic t_select();
        logic [3:0] tbl [8];
        tbl = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'h9, 4'h6, 4'ha};
        for (int c = 0; c < 8; c++)
        begin
            apb(12'h00c, 1'b1, 32'hffff451f | 32'(c << 5));
            apb(12'h00c, 1'b0, 32'h0);
            cmp("mixer rw", 32'h00004519 | 32'(c << 5), rd);
            cmp("adc source", 32'(tbl[c]), 32'(adc_src));
            cmp("sidetone src", c < 4 ? 32'(tbl[c]) : 32'h0, 32'(st_src));
            cmp("path valid", c < 4 ? 32'h1 : 32'h0, 32'(st_valid));
        end
        apb(12'h00c, 1'b1, 32'h00004560);
        cmp("adc off", 32'h0, 32'(adc_src));
        cmp("cell off", 32'h0, 32'(cell_adc));
        $display("test select done");
    endtask

    // Gain above the 12 dB point steps up and saturates, flag raises irq
    task automatic t_sidetone();
        apb(12'h00c, 1'b1, 32'h00007f10);
        apb(12'h00c, 1'b0, 32'h0);
        cmp("flag stepping", 32'h00007f10, rd);
        wclk(30);
        cmp("gain applied", 32'h5d, 32'(st_gain));
        apb(12'h00c, 1'b0, 32'h0);
        cmp("flag settled", 32'h00007f11, rd);
        apb(12'h020, 1'b0, 32'h0);
        cmp("status", 32'h1, rd);
        cmp("irq masked", 32'h0, 32'(irq));
        apb(12'h024, 1'b1, 32'h1);
        cmp("irq on", 32'h1, 32'(irq));
        apb(12'h020, 1'b1, 32'h1);
        cmp("irq cleared", 32'h0, 32'(irq));
        $display("test sidetone done");
    endtask

    // Code 4 gives 16 cycles a period, length 0 gives two periods
    task automatic t_click();
        apb(12'h010, 1'b1, 32'h0000f400);
        cmp("amplitude", 32'h7, 32'(click_amp));
        cmp("tone high", 32'h1, 32'(tone));
        repeat (24) @(posedge pclk);
        cmp("click running", 32'h1, 32'(click_act));
        cmp("tone low", 32'h0, 32'(tone));
        repeat (12) @(posedge pclk);
        cmp("click ended", 32'h0, 32'(click_act));
        apb(12'h010, 1'b0, 32'h0);
        cmp("enable cleared", 32'h00007400, rd);
        apb(12'h020, 1'b0, 32'h0);
        cmp("done status", 32'h2, rd);
        $display("test click done");
    endtask

    // Noise flag shown while AGC on, DAC flags, unmapped address
    task automatic t_agc();
        agc_enabled     <= 1'b1;
        agc_below_noise <= 1'b1;
        dac_flags       <= 1'b1;
        apb(12'h010, 1'b1, 32'h00004c10);
        apb(12'h010, 1'b0, 32'h0);
        cmp("noise flag", 32'h00004c18, rd);
        cmp("rate frozen", 32'h0, 32'(step_diff));
        agc_enabled <= 1'b0;
        apb(12'h010, 1'b1, 32'h00004c10);
        cmp("rate bit", 32'h1, 32'(step_diff));
        pga_tgt <= 7'h02;
        wclk(2);
        cmp("pga half rate", 32'h1, 32'(pga_gain));
        wclk(2);
        cmp("pga settled", 32'h2, 32'(pga_gain));
        apb(12'h100, 1'b0, 32'h0);
        cmp("unmapped", 32'h0, rd);
        cmp("slverr", 32'h1, 32'(err));
        $display("test agc done");
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        miscompares     = 0;
        checks          = 0;
        presetn         = 1'b0;
        psel            = 1'b0;
        penable         = 1'b0;
        pwrite          = 1'b0;
        paddr           = 12'h000;
        pwdata          = 32'h0;
        word_clock      = 1'b0;
        agc_enabled     = 1'b0;
        agc_below_noise = 1'b0;
        dac_flags       = 1'b0;
        dac_r           = 1'b0;
        pga_tgt         = 7'h00;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_select();
        t_sidetone();
        t_click();
        t_agc();
        end_of_test();
    end

endmodule // tb_top
